// ### common/temp_fault_consts.svh
// Command codes, field positions, reset values and encodings of the temperature supervisor.
// Included by the package and the compare and supervisor modules; holds definitions only.
`ifndef TEMP_FAULT_CONSTS_SVH
`define TEMP_FAULT_CONSTS_SVH

// Command codes of the four supervision registers
`define CODE_HOT_WARN    8'h51
`define CODE_COLD_WARN   8'h52
`define CODE_COLD_FAULT  8'h53
`define CODE_COLD_ACTION 8'h54

// Fault action byte layout
`define ACT_RESP_HI  7
`define ACT_RESP_LO  6
`define ACT_RETRY_HI 5
`define ACT_RETRY_LO 3
`define ACT_DELAY_HI 2
`define ACT_DELAY_LO 0

// Response field encodings
`define RESP_IGNORE  2'h0
`define RESP_GRACE   2'h1
`define RESP_RETRY   2'h2
`define RESP_LOCK    2'h3

// Retry field encodings
`define RETRY_NONE    3'h0
`define RETRY_FOREVER 3'h7

// Linear word layout: signed exponent above signed mantissa
`define LIN_EXP_HI  15
`define LIN_EXP_LO  11
`define LIN_MANT_HI 10
`define LIN_EXP_BIAS 6'h10

// Reset values: warning limits at the extremes so nothing fires until programmed
`define RST_HOT_WARN    16'h7bff
`define RST_COLD_WARN   16'h7c00
`define RST_COLD_FAULT  16'h7c00
`define RST_COLD_ACTION 8'h00

`endif

// ### common/temp_fault_pkg.sv
// Types shared by the temperature supervisor and its bench.
// Assumes the constants header sits beside it on the include path.
`include "temp_fault_consts.svh"

package temp_fault_pkg;

  // One command beat: write or read strobe, command code, data word
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  code;
    logic [15:0] data;
  } cmd_t;

  // Status levels reported to the rest of the converter
  typedef struct packed {
    logic hotWarn;
    logic coldWarn;
    logic coldFault;
  } flags_t;

  // Fault response sequencer, one-hot
  typedef enum logic [3:0] {
    RUNNING = 4'h1,
    GRACE   = 4'h2,
    BACKOFF = 4'h4,
    LOCKOUT = 4'h8
  } state_t;

endpackage

// ### hw/linear_compare.sv
// Signed comparison of two words in the linear number format.
// Both words come from logic on the same clock; purely combinational.
`timescale 1ns/1ns
`include "temp_fault_consts.svh"

module linear_compare (
  input  wire logic [15:0] valueA,  // Left operand, linear
  input  wire logic [15:0] valueB,  // Right operand, linear
  output logic             aAbove,  // valueA greater than valueB
  output logic             aBelow   // valueA less than valueB
);

  // Scale mantissa to a common fixed point; exponent -16 maps to shift 0
  function automatic logic signed [41:0] toFixed(input logic [15:0] w);
    logic [5:0]         shift;
    logic signed [41:0] mant;
    shift = {w[`LIN_EXP_HI], w[`LIN_EXP_HI:`LIN_EXP_LO]} + `LIN_EXP_BIAS;
    mant  = 42'(signed'(w[`LIN_MANT_HI:0]));
    toFixed = mant <<< shift;
  endfunction

  // Full-width shift keeps every exponent exact, at the cost of wide comparators
  wire logic signed [41:0] fixedA = toFixed(valueA);
  wire logic signed [41:0] fixedB = toFixed(valueB);
  assign aAbove = fixedA > fixedB;
  assign aBelow = fixedA < fixedB;

endmodule // linear_compare

// ### hw/delay_timer.sv
// Delay and retry spacing timer: runs 2**exponent units of unitCycles clocks each.
// The unit length comes from the timebase logic on the same clock.
`timescale 1ns/1ns

module delay_timer #(
  parameter int UNIT_W = 16  // Width of the unit length in clocks
) (
  input  wire logic              mclk,       // Core clock
  input  wire logic              rst,        // Asynchronous reset, high
  input  wire logic              start,      // Load and start, wins over a running count
  input  wire logic [2:0]        exponent,   // Units = 2**exponent
  input  wire logic [UNIT_W-1:0] unitCycles, // Clocks per unit, zero acts as one
  output logic                   done        // One-cycle pulse at expiry
);

  logic [UNIT_W-1:0] cyc_q;
  logic [7:0]        units_q;
  logic              busy_q;
  wire logic [UNIT_W-1:0] unitLast = (unitCycles == '0) ? '0 : UNIT_W'(unitCycles - 1'b1);
  wire logic              unitEnd  = cyc_q == '0;

  // Whole span is unitCycles * 2**exponent clocks from the start cycle
  assign done = busy_q & unitEnd & (units_q == 8'h00);

  // Counter walks down the clocks of a unit, then the units
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cyc_q   <= '0;
      units_q <= 8'h00;
      busy_q  <= 1'b0;
    end else if (start) begin
      cyc_q   <= unitLast;
      units_q <= 8'((9'h001 << exponent) - 9'h001);
      busy_q  <= 1'b1;
    end else if (busy_q) begin
      cyc_q   <= unitEnd ? unitLast : UNIT_W'(cyc_q - 1'b1);
      units_q <= unitEnd ? 8'(units_q - 8'h01) : units_q;
      busy_q  <= ~done;
    end
  end

  // Helper: clocks elapsed since start and the span that was loaded
  logic [31:0] elapsed_q;
  logic [31:0] span_q;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      elapsed_q <= 32'h0;
      span_q    <= 32'h0;
    end else if (start) begin
      elapsed_q <= 32'h1;
      span_q    <= 32'(((unitCycles == '0) ? 32'h1 : 32'(unitCycles)) << exponent);
    end else begin
      elapsed_q <= 32'(elapsed_q + 32'h1);
    end
  end

  chk_span_exact: assert property (@(posedge mclk) disable iff (rst)
    done |-> elapsed_q == span_q)
    else $error("timer expiry does not match unit length times two to the exponent");

endmodule // delay_timer

// ### hw/temp_limit_supervisor.sv
// Temperature supervisor: warning and fault limits, fault flag and the programmed
// cold-fault response sequencer with grace delay, bounded or endless retry and lockout.
// Assumes command strobes, temperature, timebase unit and run request all come
// from logic on mclk; the bus transport and number decoding sit outside.
`timescale 1ns/1ns
`include "temp_fault_consts.svh"

module temp_limit_supervisor (
  input  wire logic                  mclk,          // Core clock, 250 MHz
  input  wire logic                  rst,           // Asynchronous reset, high
  input  wire temp_fault_pkg::cmd_t  cmd,           // Command beat
  input  wire logic [15:0]           temperature,   // Measured temperature, linear
  input  wire logic [15:0]           unitCycles,    // Delay time unit in clocks
  input  wire logic                  runRequest,    // Combined pin and operation on
  input  wire logic                  clearFaults,   // Clear-faults command pulse
  input  wire logic                  clearColdBit,  // Individual status bit clear pulse
  input  wire logic                  otherShutdown, // Another fault has shut down
  output logic [15:0]                readData,      // Read answer
  output logic                       readValid,     // Read answer valid pulse
  output logic                       cmdUnknown,    // Unmapped code pulse
  output temp_fault_pkg::flags_t     flags,         // Warning and fault levels
  output logic                       outputEnable,  // Converter output allowed
  output logic                       retryActive    // Waiting between restarts
);
  import temp_fault_pkg::*;

  // Register file
  logic [15:0] hotLim_q;
  logic [15:0] coldWarnLim_q;
  logic [15:0] coldFaultLim_q;
  logic [7:0]  action_q;

  // Code decode
  wire logic isHot    = cmd.code == `CODE_HOT_WARN;
  wire logic isCold   = cmd.code == `CODE_COLD_WARN;
  wire logic isFault  = cmd.code == `CODE_COLD_FAULT;
  wire logic isAction = cmd.code == `CODE_COLD_ACTION;
  wire logic codeHit  = isHot | isCold | isFault | isAction;

  // Limit and action writes
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      hotLim_q       <= `RST_HOT_WARN;
      coldWarnLim_q  <= `RST_COLD_WARN;
      coldFaultLim_q <= `RST_COLD_FAULT;
      action_q       <= `RST_COLD_ACTION;
    end else if (cmd.wr) begin
      if (isHot)    hotLim_q       <= cmd.data;
      if (isCold)   coldWarnLim_q  <= cmd.data;
      if (isFault)  coldFaultLim_q <= cmd.data;
      if (isAction) action_q       <= cmd.data[7:0];
    end
  end

  // Read selection; the action byte reads with a zero upper byte
  wire logic [15:0] readMux =
    isHot   ? hotLim_q :
    isCold  ? coldWarnLim_q :
    isFault ? coldFaultLim_q :
    isAction ? {8'h00, action_q} : 16'h0000;

  // Read answer holds until the next read; unknown codes answer zero and pulse
  logic [15:0] readData_q;
  logic        readValid_q;
  logic        cmdUnknown_q;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      readData_q   <= 16'h0000;
      readValid_q  <= 1'b0;
      cmdUnknown_q <= 1'b0;
    end else begin
      readData_q   <= cmd.rd ? readMux : readData_q;
      readValid_q  <= cmd.rd;
      cmdUnknown_q <= (cmd.rd | cmd.wr) & ~codeHit;
    end
  end
  assign readData   = readData_q;
  assign readValid  = readValid_q;
  assign cmdUnknown = cmdUnknown_q;

  // Limit comparisons on the live temperature
  logic hotNow;
  logic coldNow;
  logic faultNow;
  linear_compare hotCmp (
    .valueA (temperature),
    .valueB (hotLim_q),
    .aAbove (hotNow),
    .aBelow ()
  );
  linear_compare coldCmp (
    .valueA (temperature),
    .valueB (coldWarnLim_q),
    .aAbove (),
    .aBelow (coldNow)
  );
  linear_compare faultCmp (
    .valueA (temperature),
    .valueB (coldFaultLim_q),
    .aAbove (),
    .aBelow (faultNow)
  );

  // Action fields, read live so a rewrite steers a response in progress
  wire logic [1:0] resp     = action_q[`ACT_RESP_HI:`ACT_RESP_LO];
  wire logic [2:0] retries  = action_q[`ACT_RETRY_HI:`ACT_RETRY_LO];
  wire logic [2:0] delayExp = action_q[`ACT_DELAY_HI:`ACT_DELAY_LO];
  wire logic       noRetry  = retries == `RETRY_NONE;
  wire logic       endless  = retries == `RETRY_FOREVER;

  // Clearing: an off edge of the run request counts, being off already kills the output
  logic runPrev_q;
  wire logic offEdge  = runPrev_q & ~runRequest;
  wire logic anyClear = clearFaults | clearColdBit | offEdge;

  // Flags; a new fault in the clearing cycle keeps the flag set
  logic hotWarn_q;
  logic coldWarn_q;
  logic coldFault_q;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      runPrev_q   <= 1'b0;
      hotWarn_q   <= 1'b0;
      coldWarn_q  <= 1'b0;
      coldFault_q <= 1'b0;
    end else begin
      runPrev_q   <= runRequest;
      hotWarn_q   <= hotNow;
      coldWarn_q  <= coldNow;
      coldFault_q <= faultNow | (coldFault_q & ~anyClear);
    end
  end
  assign flags = '{hotWarn: hotWarn_q, coldWarn: coldWarn_q, coldFault: coldFault_q};

  // Sequencer state
  state_t     state_q;
  state_t     state_d;
  logic [2:0] attempts_q;
  logic [2:0] attempts_d;
  logic       timerStart;
  logic       timerDone;
  wire logic  lastTry = ~endless & (3'(attempts_q + 3'h1) == retries);

  delay_timer #(
    .UNIT_W (16)
  ) spacing (
    .mclk       (mclk),
    .rst        (rst),
    .start      (timerStart),
    .exponent   (delayExp),
    .unitCycles (unitCycles),
    .done       (timerDone)
  );

  // Response choice; the off state and every clear return to running and reset the count
  always_comb begin
    state_d    = state_q;
    attempts_d = attempts_q;
    timerStart = 1'b0;
    if (anyClear | ~runRequest) begin
      state_d    = RUNNING;
      attempts_d = 3'h0;
    end else begin
      unique case (state_q)
        RUNNING: begin
          if (faultNow) begin
            unique case (resp)
              `RESP_IGNORE: state_d = RUNNING;
              `RESP_GRACE: begin
                state_d    = GRACE;
                timerStart = 1'b1;
              end
              `RESP_RETRY: begin
                state_d    = noRetry ? LOCKOUT : BACKOFF;
                timerStart = ~noRetry;
              end
              `RESP_LOCK: state_d = LOCKOUT;
            endcase
          end
        end
        GRACE: begin
          if (timerDone) begin
            if (!faultNow) begin
              state_d = RUNNING;
            end else begin
              state_d    = noRetry ? LOCKOUT : BACKOFF;
              timerStart = ~noRetry;
            end
          end
        end
        BACKOFF: begin
          if (otherShutdown) begin
            state_d = LOCKOUT;
          end else if (timerDone) begin
            // Each expiry is one restart attempt; the next spacing starts at once
            attempts_d = 3'(attempts_q + 3'h1);
            if (!faultNow) begin
              state_d    = RUNNING;
              attempts_d = 3'h0;
            end else if (lastTry) begin
              state_d = LOCKOUT;
            end else begin
              timerStart = 1'b1;
            end
          end
        end
        LOCKOUT: state_d = LOCKOUT;
      endcase
    end
  end

  // Output enable follows the next state so a disable takes effect one clock after the fault
  logic outputEnable_q;
  logic retryActive_q;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_q        <= RUNNING;
      attempts_q     <= 3'h0;
      outputEnable_q <= 1'b0;
      retryActive_q  <= 1'b0;
    end else begin
      state_q        <= state_d;
      attempts_q     <= attempts_d;
      outputEnable_q <= runRequest & ((state_d == RUNNING) | (state_d == GRACE));
      retryActive_q  <= state_d == BACKOFF;
    end
  end
  assign outputEnable = outputEnable_q;
  assign retryActive  = retryActive_q;

  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  wire logic quiet = runRequest & ~anyClear;

  chk_hot_readback: assert property (
    cmd.rd && isHot |=> readValid && readData == $past(hotLim_q))
    else $error("hot warning limit read back wrong");
  chk_cold_warn_wr: assert property (
    cmd.wr && isCold ##1 cmd.rd && isCold |=> readData == $past(cmd.data, 2))
    else $error("cold warning limit write not read back");
  chk_fault_lim_wr: assert property (
    cmd.wr && isFault ##1 cmd.rd && isFault |=> readData == $past(cmd.data, 2))
    else $error("cold fault limit write not read back");
  chk_action_byte: assert property (
    cmd.rd && isAction |=> readData == {8'h00, $past(action_q)})
    else $error("action byte read back wrong");
  chk_ignore_runs: assert property (
    state_q == RUNNING && faultNow && resp == `RESP_IGNORE && quiet |=> outputEnable && state_q == RUNNING)
    else $error("ignored fault interrupted the output");
  chk_grace_runs: assert property (
    state_q == RUNNING && faultNow && resp == `RESP_GRACE && quiet |=> state_q == GRACE && outputEnable)
    else $error("grace response did not keep running");
  chk_disable_now: assert property (
    state_q == RUNNING && faultNow && resp == `RESP_RETRY && quiet |=> !outputEnable)
    else $error("disable response left output on");
  chk_lock_holds: assert property (
    state_q == LOCKOUT && quiet |=> state_q == LOCKOUT && !outputEnable)
    else $error("lockout left without clear");
  chk_clear_exit: assert property (
    anyClear |=> state_q == RUNNING && attempts_q == 3'h0)
    else $error("clear did not end the response");
  chk_no_retry: assert property (
    state_q == RUNNING && faultNow && resp != `RESP_IGNORE && resp != `RESP_GRACE && noRetry && quiet
    |=> state_q == LOCKOUT)
    else $error("zero retry setting attempted a restart");
  chk_retry_bound: assert property (
    state_q == BACKOFF && !endless |-> attempts_q < retries)
    else $error("restart attempts exceeded the retry setting");
  chk_forever_on: assert property (
    state_q == BACKOFF && endless && timerDone && faultNow && quiet && !otherShutdown |=> state_q == BACKOFF)
    else $error("endless retry stopped on its own");
  chk_fault_flag: assert property (
    faultNow |=> flags.coldFault)
    else $error("cold fault not latched");
  chk_warn_levels: assert property (
    hotNow && coldNow == 1'b0 |=> flags.hotWarn && !flags.coldWarn)
    else $error("warning flags disagree with limits");

  cov_grace_backoff: cover property (state_q == GRACE ##1 state_q == BACKOFF);
  cov_retry_lockout: cover property (state_q == BACKOFF ##1 state_q == LOCKOUT);
  cov_recovered:     cover property (state_q == BACKOFF ##1 state_q == RUNNING && quiet);
  cov_clear_lock:    cover property (state_q == LOCKOUT ##1 anyClear);

endmodule // temp_limit_supervisor

// ### tb/pmbus_host_model.sv
// Host stand-in for the supervisor: issues register commands and clear pulses.
// Assumes the supervisor answers a read exactly one clock after the strobe edge.
`timescale 1ns/1ns

module pmbus_host_model (
  input  wire logic            mclk,         // Core clock
  input  wire logic [15:0]     readData,     // Read answer from the device
  input  wire logic            readValid,    // Read answer strobe
  input  wire logic            cmdUnknown,   // Unmapped code strobe
  output temp_fault_pkg::cmd_t cmd,          // Command beat
  output logic                 clearFaults,  // Clear-faults pulse
  output logic                 clearColdBit  // Status bit clear pulse
);
  import temp_fault_pkg::*;

  // Idle lines at time zero
  initial begin
    cmd          = '0;
    clearFaults  = 1'b0;
    clearColdBit = 1'b0;
  end

  // One beat: raise after an edge, hold through the taking edge, then release
  task automatic beat(input logic wr, input logic rd, input logic [7:0] code, input logic [15:0] data);
    @(posedge mclk);
    cmd <= '{wr: wr, rd: rd, code: code, data: data};
    @(posedge mclk);
    // Released lines show the inverse so a stale value never looks live
    cmd <= '{wr: 1'b0, rd: 1'b0, code: ~code, data: ~data};
  endtask

  task automatic write_cmd(input logic [7:0] code, input logic [15:0] data);
    beat(1'b1, 1'b0, code, data);
  endtask

  // Write then read the same code on consecutive edges, no idle cycle between
  task automatic write_read(input logic [7:0] code, input logic [15:0] data, output logic [15:0] rdata);
    @(posedge mclk);
    cmd <= '{wr: 1'b1, rd: 1'b0, code: code, data: data};
    @(posedge mclk);
    cmd <= '{wr: 1'b0, rd: 1'b1, code: code, data: data};
    @(posedge mclk);
    cmd <= '{wr: 1'b0, rd: 1'b0, code: ~code, data: ~data};
    @(negedge mclk);
    rdata = readData;
  endtask

  // The strobes stand one cycle, so the answer is taken at the following low phase
  task automatic read_cmd(input logic [7:0] code, output logic [15:0] data, output logic valid,
                          output logic unknown);
    beat(1'b0, 1'b1, code, 16'h0000);
    @(negedge mclk);
    data    = readData;
    valid   = readValid;
    unknown = cmdUnknown;
  endtask

  // Either clear action lasts exactly one clock
  task automatic pulse_clear(input logic bitOnly);
    @(posedge mclk);
    if (bitOnly) begin
      clearColdBit <= 1'b1;
    end else begin
      clearFaults <= 1'b1;
    end
    @(posedge mclk);
    clearFaults  <= 1'b0;
    clearColdBit <= 1'b0;
  endtask
endmodule // pmbus_host_model

// ### tb/temp_limit_fault_response_test.sv
// Self-checking bench for the supervisor: registers, warnings and every fault response.
// Assumes the host model drives commands; expectations come from a small integer model.
`timescale 1ns/1ns
`include "temp_fault_consts.svh"

module temp_limit_fault_response_test;
  import temp_fault_pkg::*;

  localparam int          WIN       = 120;      // Observation window per fault case
  localparam logic [15:0] HOT_LIM   = 16'h0050; // Exponent zero, so words read as integers
  localparam logic [15:0] WARN_LIM  = 16'h0005;
  localparam logic [15:0] FAULT_LIM = 16'h0002;
  localparam logic [15:0] WARM      = 16'h001e;
  localparam logic [15:0] COLD      = 16'h0001;

  logic        mclk;
  logic        rst;
  cmd_t        cmd;
  logic [15:0] temperature;
  logic [15:0] unitCycles;
  logic        runRequest;
  logic        clearFaults;
  logic        clearColdBit;
  logic        otherShutdown;
  logic [15:0] readData;
  logic        readValid;
  logic        cmdUnknown;
  flags_t      flags;
  logic        outputEnable;
  logic        retryActive;
  int          nErrors;
  int          samplesChecked;
  int          seed;
  int          regModel [int];
  logic [7:0]  actions [8] = '{8'h00, 8'h81, 8'h89, 8'h91, 8'h99, 8'ha9, 8'hd9, 8'h42};

  pmbus_host_model host (.mclk(mclk), .readData(readData), .readValid(readValid), .cmdUnknown(cmdUnknown),
                         .cmd(cmd), .clearFaults(clearFaults), .clearColdBit(clearColdBit));

  temp_limit_supervisor dut (.mclk(mclk), .rst(rst), .cmd(cmd), .temperature(temperature),
                             .unitCycles(unitCycles), .runRequest(runRequest), .clearFaults(clearFaults),
                             .clearColdBit(clearColdBit), .otherShutdown(otherShutdown), .readData(readData),
                             .readValid(readValid), .cmdUnknown(cmdUnknown), .flags(flags),
                             .outputEnable(outputEnable), .retryActive(retryActive));

  // Free-running core clock
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    samplesChecked++;
    if (seen !== exp) begin
      nErrors++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d, mismatches %0d", samplesChecked, nErrors);
    if (nErrors == 0 && samplesChecked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic read_back(input logic [7:0] code, input logic known);
    logic [15:0] d;
    logic        v;
    logic        u;
    host.read_cmd(code, d, v, u);
    check({15'h0000, v}, 16'h0001, "read strobe");
    check({15'h0000, u}, {15'h0000, ~known}, "unknown strobe");
    check(d, known ? 16'(regModel[code]) : 16'h0000, "read data");
  endtask

  // Model keeps only mapped codes; the action register holds its low byte
  task automatic write_reg(input logic [7:0] code, input logic [15:0] data);
    host.write_cmd(code, data);
    if (regModel.exists(code)) begin
      regModel[code] = (code == `CODE_COLD_ACTION) ? int'(data[7:0]) : int'(data);
    end
  endtask

  // Back-to-back write and read of one limit word
  task automatic write_read(input logic [7:0] code, input logic [15:0] data);
    logic [15:0] d;
    host.write_read(code, data, d);
    regModel[code] = int'(data);
    check(d, 16'(regModel[code]), "back to back read");
  endtask

  task automatic set_temp(input logic [15:0] value);
    @(posedge mclk);
    temperature <= value;
  endtask

  // Bounded wait for the output to come back; running out ends the run
  task automatic wait_oe(input int bound);
    int n;
    n = 0;
    while (outputEnable !== 1'b1 && n < bound) begin
      @(negedge mclk);
      n++;
    end
    if (outputEnable !== 1'b1) begin
      nErrors++;
      $display("wrong value at %0t: output never came back", $time);
      report_and_stop();
    end else begin
      check({15'h0000, outputEnable}, 16'h0001, "output restored");
    end
  endtask

  // Rotates through the clearing actions: clear-faults, status bit, off then on
  task automatic clear_by(input int how);
    if (how == 2) begin
      @(posedge mclk);
      runRequest <= 1'b0;
      @(posedge mclk);
      runRequest <= 1'b1;
    end else begin
      host.pulse_clear(how[0]);
    end
    @(negedge mclk);
  endtask

  // Cold event under one action byte; counts cycles on and cycles in spacing
  task automatic fault_case(input logic [7:0] action, input int unit, input int how);
    int d;
    int oeSeen;
    int raSeen;
    int oeExp;
    d = unit << action[2:0];
    oeSeen = 0;
    raSeen = 0;
    // First window sample precedes the edge that sees the fault; off one clock after it
    oeExp = (action[7:6] == 2'h0) ? WIN : (action[7:6] == 2'h1) ? d + 1 : 1;
    write_reg(`CODE_COLD_ACTION, {8'h00, action});
    @(posedge mclk);
    unitCycles <= 16'(unit);
    set_temp(COLD);
    repeat (WIN) begin
      @(negedge mclk);
      oeSeen += int'(outputEnable === 1'b1);
      raSeen += int'(retryActive === 1'b1);
    end
    check(16'(oeSeen), 16'(oeExp), "cycles with output on");
    check(16'(raSeen), 16'((action[7:6] == 2'h2) ? action[5:3] * d : 0), "spacing cycles");
    check({15'h0000, flags.coldFault}, 16'h0001, "fault latched");
    set_temp(WARM);
    repeat (10) @(negedge mclk);
    check({15'h0000, outputEnable}, {15'h0000, action[7:6] == 2'h0}, "off until cleared");
    clear_by(how);
    wait_oe(8);
    check({15'h0000, flags.coldFault}, 16'h0000, "fault cleared");
  endtask

  // Watchdog well over the run length
  initial begin
    #200000;
    nErrors++;
    $display("wrong value at %0t: run timed out", $time);
    report_and_stop();
  end

  initial begin
    seed = 25;
    rst = 1'b1;
    temperature = WARM;
    unitCycles = 16'h0002;
    runRequest = 1'b0;
    otherShutdown = 1'b0;
    regModel[`CODE_HOT_WARN] = int'(`RST_HOT_WARN);
    regModel[`CODE_COLD_WARN] = int'(`RST_COLD_WARN);
    regModel[`CODE_COLD_FAULT] = int'(`RST_COLD_FAULT);
    regModel[`CODE_COLD_ACTION] = int'(`RST_COLD_ACTION);
    repeat (8) @(posedge mclk);
    check({11'h000, flags, outputEnable, retryActive}, 16'h0000, "outputs in reset");
    rst <= 1'b0;
    @(negedge mclk);
    // Reset values, random round trips, then unmapped code
    for (int c = 'h51; c <= 'h54; c++) begin
      read_back(8'(c), 1'b1);
    end
    for (int c = 'h51; c <= 'h54; c++) begin
      write_reg(8'(c), 16'($random(seed)));
      read_back(8'(c), 1'b1);
    end
    write_reg(8'h55, 16'hbeef);
    read_back(8'h55, 1'b0);
    write_reg(`CODE_HOT_WARN, HOT_LIM);
    write_read(`CODE_COLD_WARN, WARN_LIM);
    write_read(`CODE_COLD_FAULT, FAULT_LIM);
    // A random fault limit may have latched the sticky flag; clear it before the band checks
    host.pulse_clear(1'b0);
    // Warnings with the output off so no fault response starts
    repeat (8) begin
      set_temp(16'(10 + ($random(seed) & 63)));
      repeat (2) @(negedge mclk);
      check({13'h0000, flags}, 16'h0000, "flags in band");
    end
    set_temp(16'h0064);
    repeat (2) @(negedge mclk);
    check({13'h0000, flags}, 16'h0004, "hot warning");
    set_temp(16'h0003);
    repeat (2) @(negedge mclk);
    check({13'h0000, flags}, 16'h0002, "cold warning only");
    set_temp(WARM);
    @(posedge mclk);
    runRequest <= 1'b1;
    @(negedge mclk);
    foreach (actions[i]) begin
      fault_case(actions[i], (i == 7) ? 3 : 2, i % 3);
    end
    // Endless retry, then stopped by another fault
    write_reg(`CODE_COLD_ACTION, 16'h00b8);
    set_temp(COLD);
    repeat (100) @(negedge mclk);
    check({15'h0000, retryActive}, 16'h0001, "still retrying");
    @(posedge mclk);
    otherShutdown <= 1'b1;
    repeat (3) @(negedge mclk);
    check({14'h0000, outputEnable, retryActive}, 16'h0000, "stopped by other fault");
    @(posedge mclk);
    otherShutdown <= 1'b0;
    set_temp(WARM);
    clear_by(2);
    wait_oe(8);
    // Warming during spacing lets a restart succeed
    write_reg(`CODE_COLD_ACTION, 16'h0099);
    set_temp(COLD);
    repeat (6) @(negedge mclk);
    check({15'h0000, retryActive}, 16'h0001, "spacing before restart");
    set_temp(WARM);
    @(negedge mclk);
    wait_oe(40);
    check({15'h0000, retryActive}, 16'h0000, "restart ended spacing");
    report_and_stop();
  end
endmodule // temp_limit_fault_response_test
